// ===== common/flash_cmd_pkg.sv
// shared opcodes, field sizes and link timing for the flash command decoder
package flash_cmd_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_READ_MAKER_PART      = 8'h90;
    localparam logic [7:0] OPC_READ_FACTORY_STATE   = 8'h44;
    localparam logic [7:0] OPC_ERASE_ALL_SOLID_PROT = 8'he4;
    localparam logic [7:0] OPC_WRITE_LATCH_SET      = 8'h06;
    localparam logic [7:0] OPC_WRITE_LATCH_CLEAR    = 8'h04;
    localparam logic [7:0] OPC_RESET_ARM            = 8'h66;
    localparam logic [7:0] OPC_RESET_FIRE           = 8'h99;

    // ------------------------------------------------------------
    // field sizes in bits or serial clocks
    // ------------------------------------------------------------
    localparam logic [4:0] BYTE_BITS       = 5'h08;
    localparam logic [4:0] NIBBLE_BITS     = 5'h04;
    localparam logic [4:0] ADDR_BITS       = 5'h08;
    localparam logic [4:0] DUMMY_CLKS      = 5'h10;
    localparam logic [4:0] MAKER_PART_BITS = 5'h10;
    localparam logic [4:0] STATUS_BITS     = 5'h08;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CORE_PERIOD_NS   = 100;
    localparam int SCLK_PERIOD_NS   = 800;
    localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS) < 1) ? 1 :
                                      SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0] PIN_RESET = 6'h3f;

    // opcode known and allowed in the current command mode
    function automatic logic cmd_legal(input logic [7:0] op, input logic quad);
        case (op)
            OPC_READ_MAKER_PART,
            OPC_ERASE_ALL_SOLID_PROT: cmd_legal = ~quad;
            OPC_READ_FACTORY_STATE,
            OPC_WRITE_LATCH_SET,
            OPC_WRITE_LATCH_CLEAR,
            OPC_RESET_ARM,
            OPC_RESET_FIRE:           cmd_legal = 1'b1;
            default:                  cmd_legal = 1'b0;
        endcase
    endfunction

endpackage

// ===== common/flash_link_if.sv
// serial flash link: chip select, serial clock and four two-way i/o lines
`timescale 1ns/100ps
interface flash_link_if;
    logic       cs_n;
    logic       sclk;
    logic [3:0] host_io_o;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_o;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    // undriven lines float high through the pull-up
    assign io = (host_io_oe & host_io_o) | (~host_io_oe & dev_io_oe & dev_io_o) |
                (~host_io_oe & ~dev_io_oe);

    modport dev (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
    modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
endinterface

// ===== rtl/flash_cmd_device.sv
// device end: decodes register-access, write-enable and reset commands
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
module flash_cmd_device (
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    flash_link_if.dev        link,
    input  wire logic        i_four_line_command_mode,
    input  wire logic [7:0]  i_maker_id,
    input  wire logic [7:0]  i_part_id,
    input  wire logic [7:0]  i_factory_status,
    output logic             o_write_enable_latch,
    output logic             o_erase_all_solid_prot,
    output logic             o_soft_reset,
    output logic             o_standby
);
    typedef enum logic [6:0] {
        ST_IDLE    = 7'b0000001,
        ST_OPC     = 7'b0000010,
        ST_ADDR    = 7'b0000100,
        ST_DUMMY   = 7'b0001000,
        ST_DATA    = 7'b0010000,
        ST_NODATA  = 7'b0100000,
        ST_STANDBY = 7'b1000000
    } dev_state_t;

    dev_state_t  state_ff, nxt_state;
    logic [4:0]  cnt_ff, nxt_cnt;
    logic [7:0]  sh_ff, nxt_sh;
    logic [7:0]  cmd_ff, nxt_cmd;
    logic [15:0] out_ff, nxt_out;
    logic [3:0]  io_o_ff, nxt_io_o;
    logic [3:0]  oe_ff, nxt_oe;
    logic        quad_ff, nxt_quad;
    logic        latch_ff, nxt_latch;
    logic        armed_ff, nxt_armed;
    logic        erase_ff, nxt_erase;
    logic        rst_ff, nxt_rst;
    logic [5:0]  s1_ff, s2_ff, s3_ff, lvl_ff;
    logic [5:0]  pin_lvl;
    logic        cs_fall, cs_rise, sclk_rise, sclk_fall;
    logic [4:0]  step;
    logic [7:0]  byte_in;

    // ------------------------------------------------------------
    // pin synchroniser: {cs_n, sclk, io[3:0]}
    // ------------------------------------------------------------
    // a level moves only once stages two and three agree, so one noisy sample is dropped
    assign pin_lvl   = (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
    assign cs_fall   = ~pin_lvl[5] & lvl_ff[5];
    assign cs_rise   = pin_lvl[5] & ~lvl_ff[5];
    assign sclk_rise = pin_lvl[4] & ~lvl_ff[4] & ~pin_lvl[5];
    assign sclk_fall = ~pin_lvl[4] & lvl_ff[4] & ~pin_lvl[5];

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s1_ff  <= flash_cmd_pkg::PIN_RESET;
            s2_ff  <= flash_cmd_pkg::PIN_RESET;
            s3_ff  <= flash_cmd_pkg::PIN_RESET;
            lvl_ff <= flash_cmd_pkg::PIN_RESET;
        end else begin
            s1_ff  <= {link.cs_n, link.sclk, link.io};
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= pin_lvl;
        end
    end

    // ------------------------------------------------------------
    // command decoder
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_sh    = sh_ff;
        nxt_cmd   = cmd_ff;
        nxt_out   = out_ff;
        nxt_io_o  = io_o_ff;
        nxt_oe    = oe_ff;
        nxt_quad  = quad_ff;
        nxt_latch = latch_ff;
        nxt_armed = armed_ff;
        nxt_erase = 1'b0;
        nxt_rst   = 1'b0;
        step      = quad_ff ? flash_cmd_pkg::NIBBLE_BITS : 5'h01;
        // quad: whole nibble, msb on io3; single: io0 only, io3..1 ignored
        byte_in   = quad_ff ? {sh_ff[3:0], pin_lvl[3:0]} : {sh_ff[6:0], pin_lvl[0]};
        if (cs_rise) begin
            // no-data commands run only if select rises right after the opcode
            if (state_ff == ST_NODATA) begin
                case (cmd_ff)
                    flash_cmd_pkg::OPC_WRITE_LATCH_SET:   nxt_latch = 1'b1;
                    flash_cmd_pkg::OPC_WRITE_LATCH_CLEAR: nxt_latch = 1'b0;
                    flash_cmd_pkg::OPC_ERASE_ALL_SOLID_PROT: begin
                        nxt_erase = 1'b1;
                        nxt_latch = 1'b0;
                    end
                    flash_cmd_pkg::OPC_RESET_ARM:         nxt_armed = 1'b1;
                    flash_cmd_pkg::OPC_RESET_FIRE: begin
                        // fire only straight after a completed arm
                        nxt_rst   = armed_ff;
                        nxt_latch = latch_ff & ~armed_ff;
                        nxt_armed = 1'b0;
                    end
                    default: nxt_armed = armed_ff;
                endcase
            end
            // a rejected command holds standby until select falls again
            nxt_state = (state_ff == ST_STANDBY) ? ST_STANDBY : ST_IDLE;
            nxt_oe    = 4'h0;
        end else if (cs_fall) begin
            nxt_state = ST_OPC;
            nxt_cnt   = 5'h00;
            nxt_oe    = 4'h0;
            nxt_quad  = i_four_line_command_mode;
        end else if (sclk_rise) begin
            // inputs taken on the rising edge
            case (state_ff)
                ST_OPC: begin
                    nxt_sh  = byte_in;
                    nxt_cnt = cnt_ff + step;
                    // 8 clocks single or 2 clocks quad
                    if (nxt_cnt == flash_cmd_pkg::BYTE_BITS) begin
                        nxt_cmd = byte_in;
                        nxt_cnt = 5'h00;
                        if (byte_in != flash_cmd_pkg::OPC_RESET_ARM &&
                            byte_in != flash_cmd_pkg::OPC_RESET_FIRE) begin
                            nxt_armed = 1'b0;
                        end
                        if (!flash_cmd_pkg::cmd_legal(byte_in, quad_ff)) begin
                            nxt_state = ST_STANDBY;
                        end else if (byte_in == flash_cmd_pkg::OPC_READ_MAKER_PART) begin
                            nxt_state = ST_ADDR;
                        end else if (byte_in == flash_cmd_pkg::OPC_READ_FACTORY_STATE) begin
                            nxt_state = ST_DATA;
                            nxt_out   = {i_factory_status, 8'h00};
                        end else begin
                            nxt_state = ST_NODATA;
                        end
                    end
                end
                ST_ADDR: begin
                    nxt_sh  = byte_in;
                    nxt_cnt = cnt_ff + 5'h01;
                    if (nxt_cnt == flash_cmd_pkg::ADDR_BITS) begin
                        nxt_cnt   = 5'h00;
                        nxt_state = ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    nxt_cnt = cnt_ff + 5'h01;
                    if (nxt_cnt == flash_cmd_pkg::DUMMY_CLKS) begin
                        // address bit 0 picks which id leads
                        nxt_cnt   = 5'h00;
                        nxt_state = ST_DATA;
                        nxt_out   = sh_ff[0] ? {i_part_id, i_maker_id} : {i_maker_id, i_part_id};
                    end
                end
                // a clock past the opcode breaks the byte boundary
                ST_NODATA: nxt_state = ST_STANDBY;
                default:   nxt_state = state_ff;
            endcase
        end else if (sclk_fall && state_ff == ST_DATA) begin
            // outputs change on the falling edge
            if (cmd_ff == flash_cmd_pkg::OPC_READ_MAKER_PART) begin
                // ids keep alternating while select stays low
                nxt_io_o = {2'h0, out_ff[15], 1'b0};
                nxt_oe   = 4'h2;
                nxt_out  = {out_ff[14:0], out_ff[15]};
            end else if (cnt_ff == flash_cmd_pkg::STATUS_BITS) begin
                nxt_oe    = 4'h0; // exactly one status byte
                nxt_state = ST_STANDBY;
            end else begin
                nxt_cnt  = cnt_ff + step;
                nxt_io_o = quad_ff ? out_ff[15:12] : {2'h0, out_ff[15], 1'b0};
                nxt_oe   = quad_ff ? 4'hf : 4'h2;
                nxt_out  = quad_ff ? {out_ff[11:0], 4'h0} : {out_ff[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 5'h00;
            sh_ff    <= 8'h00;
            cmd_ff   <= 8'h00;
            out_ff   <= 16'h0000;
            io_o_ff  <= 4'h0;
            oe_ff    <= 4'h0;
            quad_ff  <= 1'b0;
            latch_ff <= 1'b0;
            armed_ff <= 1'b0;
            erase_ff <= 1'b0;
            rst_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            sh_ff    <= nxt_sh;
            cmd_ff   <= nxt_cmd;
            out_ff   <= nxt_out;
            io_o_ff  <= nxt_io_o;
            oe_ff    <= nxt_oe;
            quad_ff  <= nxt_quad;
            latch_ff <= nxt_latch;
            armed_ff <= nxt_armed;
            erase_ff <= nxt_erase;
            rst_ff   <= nxt_rst;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.dev_io_o          = io_o_ff;
    assign link.dev_io_oe         = oe_ff;
    assign o_write_enable_latch   = latch_ff;
    assign o_erase_all_solid_prot = erase_ff;
    assign o_soft_reset           = rst_ff;
    assign o_standby              = (state_ff == ST_STANDBY);
endmodule

// ===== rtl/flash_cmd_host.sv
// host end: frames one command on the serial flash link per idle start request with a legal opcode; a fire needs a fresh arm
`timescale 1ns/100ps
module flash_cmd_host (
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    flash_link_if.host       link,
    input  wire logic        i_start,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_addr,
    input  wire logic        i_four_line_command_mode,
    output logic             o_busy,
    output logic [15:0]      o_rdata,
    output logic             o_rdata_valid
);
    typedef enum logic [1:0] {
        HS_IDLE = 2'b01,
        HS_RUN  = 2'b10
    } host_state_t;

    localparam logic [3:0] HALF_LAST = 4'(flash_cmd_pkg::SCLK_HALF_CYCLES - 1);

    host_state_t state_ff, nxt_state;
    logic [3:0]  div_ff, nxt_div;
    logic        sclk_ff, nxt_sclk;
    logic        cs_n_ff, nxt_cs_n;
    logic        quad_ff, nxt_quad;
    logic [5:0]  clk_cnt_ff, nxt_clk_cnt;
    logic [5:0]  tx_clks_ff, nxt_tx_clks;
    logic [5:0]  rx_start_ff, nxt_rx_start;
    logic [5:0]  total_ff, nxt_total;
    logic [15:0] tx_ff, nxt_tx;
    logic [3:0]  io_o_ff, nxt_io_o;
    logic [3:0]  oe_ff, nxt_oe;
    logic [15:0] rx_ff, nxt_rx;
    logic        valid_ff, nxt_valid;
    logic        armed_ff, nxt_armed;
    logic [3:0]  s1_ff, s2_ff, s3_ff, lvl_ff;
    logic [3:0]  io_lvl;
    logic [5:0]  rx_clks;

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    assign io_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s1_ff  <= 4'hf;
            s2_ff  <= 4'hf;
            s3_ff  <= 4'hf;
            lvl_ff <= 4'hf;
        end else begin
            s1_ff  <= link.io;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= io_lvl;
        end
    end

    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    always_comb begin
        nxt_state    = state_ff;
        nxt_div      = div_ff;
        nxt_sclk     = sclk_ff;
        nxt_cs_n     = cs_n_ff;
        nxt_quad     = quad_ff;
        nxt_clk_cnt  = clk_cnt_ff;
        nxt_tx_clks  = tx_clks_ff;
        nxt_rx_start = rx_start_ff;
        nxt_total    = total_ff;
        nxt_tx       = tx_ff;
        nxt_io_o     = io_o_ff;
        nxt_oe       = oe_ff;
        nxt_rx       = rx_ff;
        nxt_valid    = 1'b0;
        nxt_armed    = armed_ff;
        rx_clks      = 6'h00;
        case (state_ff)
            HS_IDLE: begin
                // unknown codes and a fire without a fresh arm never leave
                if (i_start && flash_cmd_pkg::cmd_legal(i_opcode, i_four_line_command_mode) &&
                    (i_opcode != flash_cmd_pkg::OPC_RESET_FIRE || armed_ff)) begin
                    nxt_armed = (i_opcode == flash_cmd_pkg::OPC_RESET_ARM);
                    nxt_state = HS_RUN;
                    nxt_quad  = i_four_line_command_mode;
                    nxt_cs_n  = 1'b0;
                    nxt_div   = 4'h0;
                    nxt_clk_cnt = 6'h00;
                    // opcode only for no-data and status commands
                    nxt_tx_clks = 6'(i_four_line_command_mode ? 5'h02 : flash_cmd_pkg::BYTE_BITS);
                    if (i_opcode == flash_cmd_pkg::OPC_READ_MAKER_PART) begin
                        nxt_tx_clks = nxt_tx_clks + 6'(flash_cmd_pkg::ADDR_BITS);
                        rx_clks     = 6'(flash_cmd_pkg::MAKER_PART_BITS);
                        nxt_rx_start = nxt_tx_clks + 6'(flash_cmd_pkg::DUMMY_CLKS);
                    end else begin
                        nxt_rx_start = nxt_tx_clks;
                        if (i_opcode == flash_cmd_pkg::OPC_READ_FACTORY_STATE) begin
                            rx_clks = i_four_line_command_mode ? 6'h02 : 6'h08;
                        end
                    end
                    nxt_total = nxt_rx_start + rx_clks;
                    // upper nibble first on the four lines
                    if (i_four_line_command_mode) begin
                        nxt_io_o = i_opcode[7:4];
                        nxt_oe   = 4'hf;
                        nxt_tx   = {i_opcode[3:0], 12'h000};
                    end else begin
                        nxt_io_o = {3'h0, i_opcode[7]};
                        nxt_oe   = 4'h1;
                        nxt_tx   = {i_opcode[6:0], i_addr, 1'b0};
                    end
                end
            end
            HS_RUN: begin
                nxt_div = div_ff + 4'h1;
                if (div_ff == HALF_LAST) begin
                    nxt_div = 4'h0;
                    if (!sclk_ff) begin
                        nxt_sclk    = 1'b1;
                        nxt_clk_cnt = clk_cnt_ff + 6'h01;
                    end else begin
                        nxt_sclk = 1'b0;
                        // late sampling: a bit launched on one fall is read at the next
                        if (clk_cnt_ff > rx_start_ff) begin
                            nxt_rx = quad_ff ? {rx_ff[11:0], io_lvl} : {rx_ff[14:0], io_lvl[1]};
                        end
                        if (clk_cnt_ff == total_ff) begin
                            // select rises on the byte boundary
                            nxt_cs_n  = 1'b1;
                            nxt_oe    = 4'h0;
                            nxt_state = HS_IDLE;
                            nxt_valid = (total_ff != rx_start_ff);
                        end else if (clk_cnt_ff < tx_clks_ff) begin
                            nxt_io_o = quad_ff ? tx_ff[15:12] : {3'h0, tx_ff[15]};
                            nxt_tx   = quad_ff ? {tx_ff[11:0], 4'h0} : {tx_ff[14:0], 1'b0};
                        end else begin
                            nxt_oe = 4'h0;
                        end
                    end
                end
            end
            default: begin
                nxt_state = HS_IDLE;
                nxt_cs_n  = 1'b1;
                nxt_oe    = 4'h0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_ff    <= HS_IDLE;
            div_ff      <= 4'h0;
            sclk_ff     <= 1'b0;
            cs_n_ff     <= 1'b1;
            quad_ff     <= 1'b0;
            clk_cnt_ff  <= 6'h00;
            tx_clks_ff  <= 6'h00;
            rx_start_ff <= 6'h00;
            total_ff    <= 6'h00;
            tx_ff       <= 16'h0000;
            io_o_ff     <= 4'h0;
            oe_ff       <= 4'h0;
            rx_ff       <= 16'h0000;
            valid_ff    <= 1'b0;
            armed_ff    <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            div_ff      <= nxt_div;
            sclk_ff     <= nxt_sclk;
            cs_n_ff     <= nxt_cs_n;
            quad_ff     <= nxt_quad;
            clk_cnt_ff  <= nxt_clk_cnt;
            tx_clks_ff  <= nxt_tx_clks;
            rx_start_ff <= nxt_rx_start;
            total_ff    <= nxt_total;
            tx_ff       <= nxt_tx;
            io_o_ff     <= nxt_io_o;
            oe_ff       <= nxt_oe;
            rx_ff       <= nxt_rx;
            valid_ff    <= nxt_valid;
            armed_ff    <= nxt_armed;
        end
    end

    assign link.cs_n       = cs_n_ff;
    assign link.sclk       = sclk_ff;
    assign link.host_io_o  = io_o_ff;
    assign link.host_io_oe = oe_ff;
    assign o_busy          = (state_ff != HS_IDLE);
    assign o_rdata         = rx_ff;
    assign o_rdata_valid   = valid_ff;
endmodule

// ===== tb/flash_link_chk.sv
// wire-level checker for the flash command link
`timescale 1ns/100ps
module flash_link_chk (
    input wire logic       i_core_clk,
    input wire logic       i_srst,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic [3:0] host_io_o,
    input wire logic [3:0] host_io_oe,
    input wire logic [3:0] dev_io_o,
    input wire logic [3:0] dev_io_oe,
    input wire logic [3:0] io
);
    logic       sclk_ff;
    logic [5:0] rises_ff;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // rises per frame; 6 bits hold the 48-clock id read
    always_ff @(posedge i_core_clk) begin
        sclk_ff  <= sclk;
        rises_ff <= cs_n ? 6'h00 : rises_ff + {5'h00, sclk & ~sclk_ff};
    end
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("sclk not low while deselected");
    a_host_off_idle: assert property (cs_n |-> host_io_oe == 4'h0)
        else $error("host drives while deselected");
    a_dev_release: assert property ($rose(cs_n) |-> ##[0:8] dev_io_oe == 4'h0)
        else $error("device keeps lines after select rise");
    a_no_contention: assert property ((host_io_oe & dev_io_oe) == 4'h0)
        else $error("both ends drive one line");
    a_sclk_in_frame: assert property ($changed(sclk) |-> !$past(cs_n))
        else $error("sclk moves outside a frame");
    a_half_period: assert property ($rose(sclk) |=> sclk[*3] ##1 !sclk)
        else $error("sclk high phase not four cycles");
    a_bit_settled: assert property ($rose(sclk) |-> $stable(host_io_o))
        else $error("host data moves at sclk rise");
    a_byte_boundary: assert property ($rose(cs_n) |-> !rises_ff[0] && !sclk)
        else $error("select rises off a boundary");
    cover property ($rose(cs_n) && rises_ff == 6'h08);
    cover property ($rose(cs_n) && rises_ff == 6'h02);
    cover property ($rose(dev_io_oe[1]));
    cover property (dev_io_oe[1] && !io[1]);
endmodule

// ===== tb/test_flash_command_decoder_write_enable.sv
// self-checking bench: host and device ends joined over the flash link
`timescale 1ns/100ps
module test_flash_command_decoder_write_enable;
    // arbitrary id and status values
    localparam logic [7:0] MAKER = 8'h3c;
    localparam logic [7:0] PART  = 8'ha5;
    localparam logic [7:0] STAT  = 8'h5a;
    logic        i_core_clk, i_srst, start, quad, busy, rvalid, latch, erase, sreset, standby;
    logic [7:0]  opcode, addr;
    logic [15:0] rdata;
    int          miscompares, cmp_count, n_val, n_ers, n_rst;
    flash_link_if link ();
    flash_cmd_host flash_cmd_host_inst (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .link(link), .i_start(start), .i_opcode(opcode), .i_addr(addr),
        .i_four_line_command_mode(quad), .o_busy(busy), .o_rdata(rdata),
        .o_rdata_valid(rvalid));
    flash_cmd_device flash_cmd_device_inst (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .link(link), .i_four_line_command_mode(quad), .i_maker_id(MAKER),
        .i_part_id(PART), .i_factory_status(STAT), .o_write_enable_latch(latch),
        .o_erase_all_solid_prot(erase), .o_soft_reset(sreset), .o_standby(standby));
    flash_link_chk flash_link_chk_inst (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .cs_n(link.cs_n), .sclk(link.sclk), .host_io_o(link.host_io_o),
        .host_io_oe(link.host_io_oe), .dev_io_o(link.dev_io_o),
        .dev_io_oe(link.dev_io_oe), .io(link.io));
    always @(posedge i_core_clk) begin
        if (rvalid === 1'b1) n_val++;
        if (erase === 1'b1) n_ers++;
        if (sreset === 1'b1) n_rst++;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    // one frame; latch and pulses land a few cycles after select rises
    task automatic run(input logic [7:0] op, input logic [7:0] ad, input logic q);
        @(posedge i_core_clk);
        #1 opcode = op; addr = ad; quad = q; start = 1'b1;
        @(posedge i_core_clk);
        #1 start = 1'b0;
        for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge i_core_clk);
        repeat (12) @(posedge i_core_clk);
    endtask
    // host frames in single mode while the device latches quad, so the device sees junk
    task automatic skew(input logic [7:0] op);
        @(posedge i_core_clk);
        #1 opcode = op; quad = 1'b0; start = 1'b1;
        @(posedge i_core_clk);
        #1 start = 1'b0; quad = 1'b1;
        for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge i_core_clk);
        repeat (12) @(posedge i_core_clk);
    endtask
    task automatic t_latch;
        for (int q = 0; q < 2; q++) begin
            run(flash_cmd_pkg::OPC_WRITE_LATCH_SET, 8'h00, q[0]);
            chk("latch set", 16'h0001, 16'(latch));
            run(flash_cmd_pkg::OPC_WRITE_LATCH_CLEAR, 8'h00, q[0]);
            chk("latch clear", 16'h0000, 16'(latch));
        end
    endtask
    task automatic t_status;
        for (int q = 0; q < 2; q++) begin
            int n = n_val;
            run(flash_cmd_pkg::OPC_READ_FACTORY_STATE, 8'h00, q[0]);
            chk("status", {8'h00, STAT}, {8'h00, rdata[7:0]});
            chk("status valid", 16'(n + 1), 16'(n_val));
        end
    endtask
    task automatic t_ident;
        run(flash_cmd_pkg::OPC_READ_MAKER_PART, 8'h00, 1'b0);
        chk("ids maker first", {MAKER, PART}, rdata);
        run(flash_cmd_pkg::OPC_READ_MAKER_PART, 8'h01, 1'b0);
        chk("ids part first", {PART, MAKER}, rdata);
        run(flash_cmd_pkg::OPC_READ_MAKER_PART, 8'h00, 1'b1);
        chk("quad id read refused", {PART, MAKER}, rdata);
    endtask
    task automatic t_standby;
        skew(flash_cmd_pkg::OPC_WRITE_LATCH_SET);
        chk("standby after junk", 16'h0001, 16'(standby));
        chk("latch after junk", 16'h0000, 16'(latch));
        run(flash_cmd_pkg::OPC_WRITE_LATCH_CLEAR, 8'h00, 1'b0);
        chk("standby after select fall", 16'h0000, 16'(standby));
    endtask
    task automatic t_erase;
        run(flash_cmd_pkg::OPC_WRITE_LATCH_SET, 8'h00, 1'b0);
        run(flash_cmd_pkg::OPC_ERASE_ALL_SOLID_PROT, 8'h00, 1'b0);
        chk("erase pulses", 16'h0001, 16'(n_ers));
        chk("latch after erase", 16'h0000, 16'(latch));
    endtask
    task automatic t_reset;
        run(flash_cmd_pkg::OPC_WRITE_LATCH_SET, 8'h00, 1'b1);
        run(flash_cmd_pkg::OPC_RESET_ARM, 8'h00, 1'b1);
        run(flash_cmd_pkg::OPC_RESET_FIRE, 8'h00, 1'b1);
        chk("reset pulses", 16'h0001, 16'(n_rst));
        chk("latch after reset", 16'h0000, 16'(latch));
        run(flash_cmd_pkg::OPC_RESET_ARM, 8'h00, 1'b0);
        run(flash_cmd_pkg::OPC_READ_FACTORY_STATE, 8'h00, 1'b0);
        run(flash_cmd_pkg::OPC_RESET_FIRE, 8'h00, 1'b0);
        chk("voided fire", 16'h0001, 16'(n_rst));
        // the device alone sees a junk code between arm and fire
        run(flash_cmd_pkg::OPC_RESET_ARM, 8'h00, 1'b0);
        skew(flash_cmd_pkg::OPC_RESET_ARM);
        run(flash_cmd_pkg::OPC_RESET_FIRE, 8'h00, 1'b0);
        chk("fire after junk", 16'h0001, 16'(n_rst));
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    // longest frame is about 400 cycles; generous margin
    initial begin
        #2000000;
        miscompares++;
        final_report;
    end
    initial begin
        i_srst = 1'b1; start = 1'b0; opcode = 8'h00; addr = 8'h00; quad = 1'b0;
        repeat (20) @(posedge i_core_clk);
        #1 i_srst = 1'b0;
        repeat (8) @(posedge i_core_clk);
        t_latch;
        t_status;
        t_ident;
        t_standby;
        t_erase;
        t_reset;
        final_report;
    end
endmodule
